// ### hcs_consts.vh
`ifndef HCS_CONSTS_VH
`define HCS_CONSTS_VH

// Register byte offsets
`define HCS_ADDR_VENDOR    8'h00
`define HCS_ADDR_PRODUCT   8'h04
`define HCS_ADDR_RELEASE   8'h08
`define HCS_ADDR_FEAT      8'h0C
`define HCS_ADDR_CTRL      8'h10
`define HCS_ADDR_STAT      8'h14

// Configuration source select encodings {high, low}
`define HCS_SRC_RESERVED   2'h0
`define HCS_SRC_SMBUS      2'h1
`define HCS_SRC_DEFAULT    2'h2
`define HCS_SRC_EEPROM     2'h3

// SMBus slave address used in SMBus download mode
`define HCS_SMBUS_ADDR     7'h2C

// Feature register field positions
`define HCS_FEAT_SELF      0
`define HCS_FEAT_IND       1
`define HCS_FEAT_HSDIS     2

// Control register field positions
`define HCS_CTRL_DONE      0

// Status register field positions
`define HCS_STAT_SRC_LO    0
`define HCS_STAT_SRC_HI    1
`define HCS_STAT_DONE      2
`define HCS_STAT_ERR       3
`define HCS_STAT_NPB_LO    4
`define HCS_STAT_NPB_HI    7
`define HCS_STAT_SMB_LO    8
`define HCS_STAT_SMB_HI    14

// Reset values
`define HCS_RST_WORD16     16'h0000
`define HCS_RST_PORTS      7'h00
`define HCS_RST_RDATA      32'h0000_0000

// Timing: cycles after reset release before the straps are trusted
`define HCS_SETTLE_CYCLES  3'h4

// Transaction translator layout
`define HCS_NP_BUFFERS     4'h4

`endif

// ### hcs_cfg_mem.v
`timescale 1ns/100ps
`default_nettype none

module hcs_cfg_mem #(
   parameter WIDTH = 16,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // Clock and reset
   input  wire             sys_clk,
   input  wire             rst_n,
   // Write side
   input  wire             wrEn,
   input  wire [AW-1:0]    wrAddr,
   input  wire [WIDTH-1:0] wrData,
   // Read side, data one cycle after rdEn
   input  wire             rdEn,
   input  wire [AW-1:0]    rdAddr,
   output reg  [WIDTH-1:0] rdData
);

   reg [WIDTH-1:0] store [0:DEPTH-1];

   // Array itself is not reset: the loader tracks which words were written, others go unused
   always @(posedge sys_clk) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= {WIDTH{1'b0}};
      end else if (rdEn) begin
         rdData <= store[rdAddr];
      end
   end

endmodule // hcs_cfg_mem

`default_nettype wire

// ### hcs_config_select.v
`timescale 1ns/100ps
`default_nettype none
`include "hcs_consts.vh"

module hcs_config_select #(
   parameter [15:0] DEFAULT_VENDOR_ID  = 16'h1234, // Arbitrary value
   parameter [15:0] DEFAULT_PRODUCT_ID = 16'h5678, // Arbitrary value
   parameter [15:0] DEFAULT_RELEASE    = 16'h0100, // Arbitrary value
   parameter [6:0]  BUS_POWER_PORTS    = 7'h7F,
   parameter        NUM_PORTS          = 7
) (
   // Clock and reset
   input  wire                 sys_clk,
   input  wire                 rst_n,
   // Strap pins, asynchronous to sys_clk
   input  wire                 configSourceSelectHigh,
   input  wire                 configSourceSelectLow,
   input  wire                 localPowerDetect,
   input  wire                 indicatorStrap,
   // Register port from the SMBus slave or EEPROM reader
   input  wire [7:0]           regAddr,
   input  wire [31:0]          regWrData,
   input  wire                 regWrite,
   input  wire                 regRead,
   output reg  [31:0]          regRdData,
   // Applied configuration
   output reg  [15:0]          vendorIdentifier,
   output reg  [15:0]          productIdentifier,
   output reg  [15:0]          releaseNumber,
   output reg                  selfPowered,
   output reg                  portIndicatorEnable,
   output reg                  fullSpeedOnly,
   output reg  [NUM_PORTS-1:0] portAvailable,
   output reg  [NUM_PORTS-1:0] translatorEnable,
   // Source and progress
   output reg  [1:0]           configSource,
   output reg                  smbusSlaveEnable,
   output reg                  eepromReadEnable,
   output reg                  configDone,
   output reg                  configError,
   output reg                  attachEnable
);

   localparam [5:0] ST_SETTLE = 6'h01;
   localparam [5:0] ST_PICK   = 6'h02;
   localparam [5:0] ST_LOAD   = 6'h04;
   localparam [5:0] ST_COPY   = 6'h08;
   localparam [5:0] ST_DONE   = 6'h10;
   localparam [5:0] ST_HALT   = 6'h20;

   // Word index of a loadable register, or 3'h4 when the address is none
   function [2:0] cfgIndex;
      input [7:0] addr;
      begin
         case (addr)
            `HCS_ADDR_VENDOR:  cfgIndex = 3'h0;
            `HCS_ADDR_PRODUCT: cfgIndex = 3'h1;
            `HCS_ADDR_RELEASE: cfgIndex = 3'h2;
            `HCS_ADDR_FEAT:    cfgIndex = 3'h3;
            default:           cfgIndex = 3'h4;
         endcase
      end
   endfunction

   // Take the later stage where two stages agree, else keep the held value, so a glitch
   // shorter than one clock never reaches the source decode
   function [3:0] strapFilter;
      input [3:0] held;
      input [3:0] mid;
      input [3:0] last;
      begin
         strapFilter = (last & ~(mid ^ last)) | (held & (mid ^ last));
      end
   endfunction

   // Memory word if the loader wrote it, else the built-in fallback, so a skipped word
   // never copies uninitialised storage into the outputs
   function [15:0] pickWord;
      input        loaded;
      input [15:0] fromMem;
      input [15:0] fallback;
      begin
         pickWord = loaded ? fromMem : fallback;
      end
   endfunction

   reg  [5:0]  state;
   reg  [2:0]  settleCnt;
   reg  [2:0]  copyIdx;
   reg  [3:0]  strapS1;
   reg  [3:0]  strapS2;
   reg  [3:0]  strapS3;
   reg  [3:0]  strapStable;
   wire [2:0]  wrIndex;
   wire        memWrEn;
   wire        memRdEn;
   wire [15:0] memRdData;
   wire        loadDoneWrite;
   reg  [3:0]  wordLoaded;
   wire [15:0] featWord;
   wire        selHighSync;
   wire        selLowSync;
   wire        powerSync;
   wire        indicatorSync;

   assign wrIndex       = cfgIndex(regAddr);
   // Writes are taken only while a download is open, so values hold afterwards
   assign memWrEn       = regWrite && (state == ST_LOAD) && !wrIndex[2];
   assign loadDoneWrite = regWrite && (state == ST_LOAD) && (regAddr == `HCS_ADDR_CTRL)
                          && regWrData[`HCS_CTRL_DONE];
   assign memRdEn       = (state == ST_COPY) && !copyIdx[2];
   assign featWord      = pickWord(wordLoaded[3], memRdData, 16'h0000);
   // Filtered strap bits as the source decode sees them
   assign selHighSync   = strapStable[3];
   assign selLowSync    = strapStable[2];
   assign powerSync     = strapStable[1];
   assign indicatorSync = strapStable[0];

   hcs_cfg_mem #(
      .WIDTH (16),
      .DEPTH (4),
      .AW    (2)
   ) uMem (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .wrEn    (memWrEn),
      .wrAddr  (wrIndex[1:0]),
      .wrData  (regWrData[15:0]),
      .rdEn    (memRdEn),
      .rdAddr  (copyIdx[1:0]),
      .rdData  (memRdData)
   );

   // A word counts as loaded once the open loader has written it
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wordLoaded <= 4'h0;
      end else if (memWrEn) begin
         wordLoaded[wrIndex[1:0]] <= 1'b1;
      end
   end

   // Straps: bit3 sel high, bit2 sel low, bit1 local power, bit0 indicator
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strapS1     <= 4'h0;
         strapS2     <= 4'h0;
         strapS3     <= 4'h0;
         strapStable <= 4'h0;
      end else begin
         strapS1     <= {configSourceSelectHigh, configSourceSelectLow,
                         localPowerDetect, indicatorStrap};
         strapS2     <= strapS1;
         strapS3     <= strapS2;
         // A bit changes only once the second and third stages agree
         strapStable <= strapFilter(strapStable, strapS2, strapS3);
      end
   end

   // Ports and translators follow the power mode chosen at commit time
   function [NUM_PORTS-1:0] portsFor;
      input self;
      begin
         portsFor = self ? {NUM_PORTS{1'b1}} : BUS_POWER_PORTS[NUM_PORTS-1:0];
      end
   endfunction

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state               <= ST_SETTLE;
         settleCnt           <= 3'h0;
         copyIdx             <= 3'h0;
         vendorIdentifier    <= `HCS_RST_WORD16;
         productIdentifier   <= `HCS_RST_WORD16;
         releaseNumber       <= `HCS_RST_WORD16;
         selfPowered         <= 1'b0;
         portIndicatorEnable <= 1'b0;
         fullSpeedOnly       <= 1'b0;
         portAvailable       <= `HCS_RST_PORTS;
         translatorEnable    <= `HCS_RST_PORTS;
         configSource        <= `HCS_SRC_RESERVED;
         smbusSlaveEnable    <= 1'b0;
         eepromReadEnable    <= 1'b0;
         configDone          <= 1'b0;
         configError         <= 1'b0;
         attachEnable        <= 1'b0;
      end else begin
         case (state)
            ST_SETTLE: begin
               // Let the synchronisers fill before the straps are believed
               if (settleCnt == `HCS_SETTLE_CYCLES) begin
                  state <= ST_PICK;
               end else begin
                  settleCnt <= settleCnt + 3'h1;
               end
            end
            ST_PICK: begin
               configSource <= {selHighSync, selLowSync};
               case ({selHighSync, selLowSync})
                  `HCS_SRC_SMBUS: begin
                     smbusSlaveEnable <= 1'b1;
                     state            <= ST_LOAD;
                  end
                  `HCS_SRC_EEPROM: begin
                     eepromReadEnable <= 1'b1;
                     state            <= ST_LOAD;
                  end
                  `HCS_SRC_DEFAULT: begin
                     vendorIdentifier    <= DEFAULT_VENDOR_ID;
                     productIdentifier   <= DEFAULT_PRODUCT_ID;
                     releaseNumber       <= DEFAULT_RELEASE;
                     selfPowered         <= powerSync;
                     portIndicatorEnable <= indicatorSync;
                     fullSpeedOnly       <= 1'b0;
                     portAvailable       <= portsFor(powerSync);
                     translatorEnable    <= portsFor(powerSync);
                     state               <= ST_DONE;
                  end
                  default: begin
                     // Reserved code: no source, never attach
                     configError <= 1'b1;
                     state       <= ST_HALT;
                  end
               endcase
            end
            ST_LOAD: begin
               if (loadDoneWrite) begin
                  copyIdx <= 3'h0;
                  state   <= ST_COPY;
               end
            end
            ST_COPY: begin
               // Read of word k is issued while word k-1 arrives
               copyIdx <= copyIdx + 3'h1;
               case (copyIdx)
                  3'h1: begin
                     vendorIdentifier <= pickWord(wordLoaded[0], memRdData,
                                                  DEFAULT_VENDOR_ID);
                  end
                  3'h2: begin
                     productIdentifier <= pickWord(wordLoaded[1], memRdData,
                                                   DEFAULT_PRODUCT_ID);
                  end
                  3'h3: begin
                     releaseNumber <= pickWord(wordLoaded[2], memRdData,
                                               DEFAULT_RELEASE);
                  end
                  3'h4: begin
                     selfPowered         <= featWord[`HCS_FEAT_SELF];
                     portIndicatorEnable <= featWord[`HCS_FEAT_IND];
                     fullSpeedOnly       <= featWord[`HCS_FEAT_HSDIS];
                     portAvailable       <= portsFor(featWord[`HCS_FEAT_SELF]);
                     translatorEnable    <= portsFor(featWord[`HCS_FEAT_SELF]);
                     smbusSlaveEnable    <= 1'b0;
                     eepromReadEnable    <= 1'b0;
                     state               <= ST_DONE;
                  end
                  default: copyIdx <= copyIdx + 3'h1;
               endcase
            end
            ST_DONE: begin
               configDone   <= 1'b1;
               attachEnable <= 1'b1;
            end
            ST_HALT: begin
               attachEnable <= 1'b0;
            end
            default: begin
               state <= ST_SETTLE;
            end
         endcase
      end
   end

   // Read data stand only in the cycle after the read strobe
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= `HCS_RST_RDATA;
      end else if (regRead) begin
         case (regAddr)
            `HCS_ADDR_VENDOR:  regRdData <= {16'h0000, vendorIdentifier};
            `HCS_ADDR_PRODUCT: regRdData <= {16'h0000, productIdentifier};
            `HCS_ADDR_RELEASE: regRdData <= {16'h0000, releaseNumber};
            `HCS_ADDR_FEAT:    regRdData <= {29'h0,
                                             fullSpeedOnly,
                                             portIndicatorEnable,
                                             selfPowered};
            `HCS_ADDR_CTRL:    regRdData <= {31'h0, configDone};
            // Status also reports the fixed slave address and buffers per translator
            `HCS_ADDR_STAT:    regRdData <= {17'h0,
                                             `HCS_SMBUS_ADDR,
                                             `HCS_NP_BUFFERS,
                                             configError,
                                             configDone,
                                             configSource};
            default:           regRdData <= `HCS_RST_RDATA;
         endcase
      end else begin
         regRdData <= `HCS_RST_RDATA;
      end
   end

endmodule // hcs_config_select

`default_nettype wire

// ### hcs_config_select_checker.sv
`timescale 1ns/100ps
`default_nettype none
module hcs_config_select_checker #(
   parameter NUM_PORTS = 7
) (
   // Clock and reset
   input wire logic                 sys_clk,
   input wire logic                 rst_n,
   // Observed ports
   input wire logic                 regRead,
   input wire logic [7:0]           regAddr,
   input wire logic [31:0]          regRdData,
   input wire logic [15:0]          vendorIdentifier,
   input wire logic                 selfPowered,
   input wire logic                 fullSpeedOnly,
   input wire logic [NUM_PORTS-1:0] portAvailable,
   input wire logic [NUM_PORTS-1:0] translatorEnable,
   input wire logic [1:0]           configSource,
   input wire logic                 smbusSlaveEnable,
   input wire logic                 eepromReadEnable,
   input wire logic                 configDone,
   input wire logic                 configError,
   input wire logic                 attachEnable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_doneAttach; configDone == attachEnable; endproperty
   a_doneAttach: assert property (p_doneAttach) else $error("attach differs from done");
   property p_holdCfg; configDone |=> configDone && $stable(vendorIdentifier)
      && $stable(selfPowered) && $stable(configSource); endproperty
   a_holdCfg: assert property (p_holdCfg) else $error("loaded values moved");
   property p_selfPorts; configDone && selfPowered |-> &portAvailable; endproperty
   a_selfPorts: assert property (p_selfPorts) else $error("self-powered ports missing");
   property p_perPortTt; configDone |-> translatorEnable == portAvailable; endproperty
   a_perPortTt: assert property (p_perPortTt) else $error("translator per port");
   property p_reserved; configError |-> !attachEnable && configSource == 2'h0; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code attached");
   property p_loader; !(smbusSlaveEnable && eepromReadEnable)
      && (!smbusSlaveEnable || configSource == 2'h1)
      && (!eepromReadEnable || configSource == 2'h3); endproperty
   a_loader: assert property (p_loader) else $error("wrong loader open");
   property p_statRead; regRead && regAddr == 8'h14 |=>
      regRdData[14:4] == {7'h2C, 4'h4} && regRdData[1:0] == configSource; endproperty
   a_statRead: assert property (p_statRead) else $error("status word wrong");
   property p_defaultFs; configDone && configSource == 2'h2 |-> !fullSpeedOnly; endproperty
   a_defaultFs: assert property (p_defaultFs) else $error("default mode full speed");
endmodule // hcs_config_select_checker

bind hcs_config_select hcs_config_select_checker #(.NUM_PORTS(NUM_PORTS)) uChecker (
   .sys_clk, .rst_n, .regRead, .regAddr, .regRdData, .vendorIdentifier, .selfPowered,
   .fullSpeedOnly, .portAvailable, .translatorEnable, .configSource, .smbusSlaveEnable,
   .eepromReadEnable, .configDone, .configError, .attachEnable);
`default_nettype wire

// ### hcs_strap_board.sv
`timescale 1ns/100ps
`default_nettype none
module hcs_strap_board (
   // Board settings
   input  wire logic [1:0] selCode,
   input  wire logic       localSupply,
   input  wire logic       ledFitted,
   // Strap pins
   output wire logic       selHigh,
   output wire logic       selLow,
   output wire logic       powerDetect,
   output wire logic       indStrap
);
   assign {selHigh, selLow} = selCode;
   // Pin low when only upstream power exists
   assign powerDetect = localSupply;
   assign indStrap = ledFitted;
endmodule // hcs_strap_board
`default_nettype wire

// ### hcs_config_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module hcs_config_select_tb_top;
   logic        sys_clk, rst_n, regWrite, regRead, supply, led;
   logic [1:0]  code;
   logic [7:0]  regAddr;
   logic [31:0] regWrData, regRdData, rd;
   logic [15:0] venId, prodId, relNum;
   logic        selHi, selLo, pwrDet, indS, sp, ind, fs, done, err, att, smbEn, eeEn;
   logic [6:0]  ports, tts;
   logic [1:0]  src;
   int          nMismatch = 0;
   int          checksDone = 0;

   hcs_strap_board board (.selCode(code), .localSupply(supply), .ledFitted(led),
      .selHigh(selHi), .selLow(selLo), .powerDetect(pwrDet), .indStrap(indS));
   hcs_config_select uut (.sys_clk(sys_clk), .rst_n(rst_n),
      .configSourceSelectHigh(selHi), .configSourceSelectLow(selLo),
      .localPowerDetect(pwrDet), .indicatorStrap(indS), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .vendorIdentifier(venId), .productIdentifier(prodId), .releaseNumber(relNum),
      .selfPowered(sp), .portIndicatorEnable(ind), .fullSpeedOnly(fs), .portAvailable(ports),
      .translatorEnable(tts), .configSource(src), .smbusSlaveEnable(smbEn),
      .eepromReadEnable(eeEn), .configDone(done), .configError(err), .attachEnable(att));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         nMismatch++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask

   task automatic rdReg(logic [7:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1 rd = regRdData;
   endtask

   // Straps settle under reset, well ahead of release
   task automatic resetWith(logic [1:0] c, logic p, logic l);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      code <= c;
      supply <= p;
      led <= l;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask

   task automatic runMode(logic [1:0] c, logic p, logic l, logic [15:0] v, logic [15:0] pr,
                          logic [15:0] dv, logic [2:0] f);
      logic dflt;
      int   i;
      dflt = (c == 2'h2);
      resetWith(c, p, l);
      repeat (8) @(posedge sys_clk);
      chk("smbus loader", c == 2'h1, smbEn);
      chk("eeprom loader", c == 2'h3, eeEn);
      if (!dflt) begin
         wr(8'h00, {16'hFFFF, v});
         wr(8'h04, {16'h0, pr});
         wr(8'h08, {16'h0, dv});
         wr(8'h0C, {29'h0, f});
         wr(8'h10, 32'h1);
      end
      for (i = 0; i < 40 && done !== 1'b1; i++) @(posedge sys_clk);
      #1;
      chk("source", c, src);
      chk("error", c == 2'h0, err);
      chk("attach", c != 2'h0, att);
      if (c == 2'h0) return;
      chk("vendor", dflt ? 16'h1234 : v, venId);
      chk("product", dflt ? 16'h5678 : pr, prodId);
      chk("release", dflt ? 16'h0100 : dv, relNum);
      chk("self power", dflt ? p : f[0], sp);
      chk("indicator", dflt ? l : f[1], ind);
      chk("full speed", dflt ? 1'b0 : f[2], fs);
      chk("ports", 7'h7F, ports);
      chk("translators", 7'h7F, tts);
      rdReg(8'h14);
      chk("status", {17'h0, 7'h2C, 4'h4, 2'b01, c}, rd);
      rdReg(8'h00);
      chk("vendor word", {16'h0, dflt ? 16'h1234 : v}, rd);
      rdReg(8'h0C);
      chk("feature word", {29'h0, dflt ? {1'b0, l, p} : f}, rd);
      rdReg(8'h40);
      chk("unmapped", 32'h0, rd);
      wr(8'h00, 32'h0000_0BAD);
      supply <= ~p;
      repeat (4) @(posedge sys_clk);
      #1;
      chk("vendor held", dflt ? 16'h1234 : v, venId);
      chk("power held", dflt ? p : f[0], sp);
   endtask

   task automatic finishTest;
      $display("Checks %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      regAddr = 8'h00;
      regWrData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      rst_n = 1'b0;
      code = 2'h2;
      supply = 1'b1;
      led = 1'b1;
      runMode(2'h2, 1'b1, 1'b1, 16'h0, 16'h0, 16'h0, 3'h0);
      runMode(2'h2, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 3'h0);
      runMode(2'h1, 1'b1, 1'b0, 16'hABCD, 16'h0042, 16'h0213, 3'b110);
      runMode(2'h3, 1'b0, 1'b1, 16'h4D2E, 16'h1F00, 16'h0999, 3'b001);
      runMode(2'h0, 1'b1, 1'b1, 16'h0, 16'h0, 16'h0, 3'h0);
      finishTest;
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      nMismatch++;
      finishTest;
   end
endmodule // hcs_config_select_tb_top
`default_nettype wire
